// ===== dv/pfsa_flash_model.sv
// Behavioural word-wide flash array behind the sequencer
`timescale 1ns/1ps
module pfsa_flash_model
   import pfsa_pkg::*;
(
   input  wire logic               CLOCK_I,    // Core clock
   input  wire logic [WADDR_W-1:0] FL_ADDR_O,  // Word address
   input  wire logic               FL_RD_O,    // Read strobe
   output logic      [15:0]        FL_RDATA_I, // Word, next cycle
   input  wire logic               FL_ERASE_O, // Row erase
   input  wire logic               FL_PROG_O,  // Block program
   input  wire logic [NHOLD*8-1:0] FL_WDATA_O, // Block data
   input  wire logic [NHOLD-1:0]   FL_WMASK_O  // Bytes to program
);
   logic [15:0] mem [0:255];
   logic        er_d = 0;
   logic        pg_d = 0;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 257) ^ 16'h5AC3;
   initial FL_RDATA_I = 16'h0000;
   // Valid mid-cycle for the fetch edge; else inverted
   always @(negedge CLOCK_I)
      FL_RDATA_I <= FL_RD_O ? mem[FL_ADDR_O[7:0]] : ~FL_RDATA_I;
   always @(posedge CLOCK_I) begin
      er_d <= FL_ERASE_O;
      pg_d <= FL_PROG_O;
      if (FL_ERASE_O && !er_d)
         for (int i = 0; i < 32; i++) mem[{FL_ADDR_O[7:5], 5'(i)}] = '1;
      if (FL_PROG_O && !pg_d)
         for (int i = 0; i < 8; i++)
            if (FL_WMASK_O[i])
               mem[{FL_ADDR_O[7:2], 2'(i / 2)}][(i % 2) * 8 +: 8] &=
                  FL_WDATA_O[i * 8 +: 8];
   end
endmodule

// ===== dv/pfsa_top_asserts.sv
// Port-level assertions for the flash self-access sequencer
`timescale 1ns/1ps
module pfsa_top_asserts
   import pfsa_pkg::*;
#(
   parameter int ERASE_CYCLES = 20, // Row erase time
   parameter int PROG_CYCLES  = 20  // Block program time
)(
   input wire logic               CLOCK_I,        // Clock
   input wire logic               NRST_I,         // Reset, low
   input wire logic               S_AXI_BVALID_O, // Write answer
   input wire logic               FL_RD_O,        // Read strobe
   input wire logic               FL_ERASE_O,     // Erase active
   input wire logic               FL_PROG_O,      // Program active
   input wire logic [NHOLD*8-1:0] FL_WDATA_O,     // Block data
   input wire logic [NHOLD-1:0]   FL_WMASK_O,     // Byte mask
   input wire logic               CORE_STALL_O    // Core halted
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   logic [NHOLD-1:0] ff_m;
   logic [TMR_W-1:0] elen_r;
   always_comb
      for (int i = 0; i < NHOLD; i++) ff_m[i] = FL_WDATA_O[i*8+:8] != HOLD_RESET;
   always_ff @(posedge CLOCK_I or negedge NRST_I)
      if (!NRST_I) elen_r <= '0;
      else elen_r <= FL_ERASE_O ? elen_r + TMR_W'(1) : '0;
   sequence erase_go_s; !FL_ERASE_O ##1 FL_ERASE_O; endsequence
   sequence prog_hold_s; CORE_STALL_O ##1 CORE_STALL_O[*4]; endsequence
   one_byte_a: assert property (FL_RD_O |=> !FL_RD_O)
      else $error("fetch strobe longer than one cycle");
   erase_stall_a: assert property (erase_go_s |-> CORE_STALL_O && !FL_PROG_O)
      else $error("erase without core stall");
   erase_time_a: assert property ($fell(FL_ERASE_O) |->
      elen_r >= ERASE_CYCLES - 2 && elen_r <= ERASE_CYCLES + 2)
      else $error("erase length off");
   prog_stall_a: assert property ($rose(FL_PROG_O) |-> prog_hold_s)
      else $error("program without held stall");
   prog_mask_a: assert property (FL_PROG_O |-> FL_WMASK_O == ff_m)
      else $error("program mask disagrees with data");
   stall_quiet_a: assert property (CORE_STALL_O |-> !S_AXI_BVALID_O)
      else $error("answer during long write");
   stall_end_a: assert property ($fell(CORE_STALL_O) |-> ##[0:4] S_AXI_BVALID_O)
      else $error("no answer after long write");
   single_op_a: assert property (!(FL_ERASE_O && FL_PROG_O))
      else $error("erase and program together");
endmodule
bind pfsa_top pfsa_top_asserts #(.ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES(PROG_CYCLES)) u_chk (.*);

// ===== dv/pfsa_top_test.sv
// Self-checking bench for the flash self-access sequencer
`timescale 1ns/1ps
module program_flash_self_access_test
   import pfsa_pkg::*;
;
   logic CLOCK_I = 0, NRST_I = 0, SYS_RESET_I = 0;
   logic [7:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0, FL_WMASK_O, v;
   logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O;
   logic [3:0] S_AXI_WSTRB_I = 4'hF;
   logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
   logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, S_AXI_AWREADY_O;
   logic S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic FL_RD_O, FL_ERASE_O, FL_PROG_O, CORE_STALL_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
   logic [15:0] FL_RDATA_I;
   logic [WADDR_W-1:0] FL_ADDR_O;
   logic [63:0] FL_WDATA_O;
   logic [7:0] mir [0:511];
   logic [33:0] rq [$], bq [$];
   int n_fail = 0, comparisons = 0, cyc = 0, n_long = 0, seed = 48;
   pfsa_top #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) dut (.*);
   pfsa_flash_model u_flash (.*);
   always #4 CLOCK_I = ~CLOCK_I;
   always @(posedge CORE_STALL_O) n_long++;
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic compare(string nm, logic [33:0] e, logic [33:0] s);
      comparisons++;
      if (e !== s) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   always @(posedge CLOCK_I) begin
      cyc++;
      if (cyc == 20000) begin n_fail++; conclude(); end
   end
   always @(posedge CLOCK_I) begin
      if (S_AXI_RVALID_O === 1'b1 && S_AXI_RREADY_I)
         compare("read", rq.pop_front(), {S_AXI_RRESP_O, S_AXI_RDATA_O});
      if (S_AXI_BVALID_O === 1'b1 && S_AXI_BREADY_I)
         compare("bresp", bq.pop_front(), 34'(S_AXI_BRESP_O));
   end
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 0);
      logic ha, hw, hb;
      bq.push_back(34'(r));
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
      do begin
         @(negedge CLOCK_I);
         ha = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
         hw = S_AXI_WVALID_I & S_AXI_WREADY_O;
         hb = S_AXI_BVALID_O;
         @(posedge CLOCK_I);
         if (ha) S_AXI_AWVALID_I <= 0;
         if (hw) S_AXI_WVALID_I <= 0;
      end while (hb !== 1'b1);
      S_AXI_BREADY_I <= 0;
      @(posedge CLOCK_I);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r = 0);
      logic ha, hr;
      rq.push_back({r, d});
      S_AXI_ARADDR_I <= a;
      {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h3;
      do begin
         @(negedge CLOCK_I);
         ha = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
         hr = S_AXI_RVALID_O;
         @(posedge CLOCK_I);
         if (ha) S_AXI_ARVALID_I <= 0;
      end while (hr !== 1'b1);
      S_AXI_RREADY_I <= 0;
      @(posedge CLOCK_I);
   endtask
   task automatic chk(int b, int m = 0);
      wr(OFS_PTR, b);
      wr(OFS_TBLOP, 32'(m * 2));
      rd(OFS_LATCH, 32'(mir[m == 3 ? b + 1 : b]));
      rd(OFS_PTR, 32'(m == 2 ? b - 1 : m == 0 ? b : b + 1));
   endtask
   task automatic store(int b);
      v = mir[b] & 8'($random(seed));
      mir[b] = v;
      wr(OFS_PTR, b);
      wr(OFS_LATCH, v);
      wr(OFS_TBLOP, 1);
   endtask
   task automatic go(logic [31:0] c);
      wr(OFS_CTRL, c);
      wr(OFS_KEY, KEY_FIRST);
      wr(OFS_KEY, KEY_SECOND);
      wr(OFS_CTRL, c | 32'h2);
   endtask
   initial begin
      for (int i = 0; i < 256; i++) {mir[2*i+1], mir[2*i]} = 16'(i * 257) ^ 16'h5AC3;
      repeat (20) @(posedge CLOCK_I);
      NRST_I <= 1;
      @(posedge CLOCK_I);
      rd(OFS_CTRL, 0);
      rd(8'h18, 0, RESP_SLVERR);
      wr(8'h1C, 1, RESP_SLVERR);
      for (int m = 0; m < 4; m++) chk(32'h21 + m, m);
      for (int i = 1; i < 8; i += 3) store(32'h48 + i);
      go(32'h84);
      rd(OFS_CTRL, 32'h84);
      rd(OFS_STAT, 32'h1);
      wr(OFS_STAT, 1);
      rd(OFS_STAT, 0);
      store(32'h50);
      go(32'h84);
      for (int i = 0; i < 16; i++) chk(32'h48 + i);
      wr(OFS_CTRL, 32'h86);
      rd(OFS_CTRL, 32'h8C);
      wr(OFS_KEY, KEY_FIRST);
      wr(OFS_PTR, 32'hE5);
      wr(OFS_KEY, KEY_SECOND);
      wr(OFS_CTRL, 32'h86);
      go(32'h80);
      rd(OFS_CTRL, 32'h88);
      wr(OFS_PTR, 32'hE5);
      go(32'h94);
      for (int i = 32'hC0; i < 32'h100; i++) mir[i] = 8'hFF;
      rd(OFS_CTRL, 32'h84);
      chk(32'hBF);
      chk(32'hC0);
      chk(32'hFF);
      store(32'h58);
      fork
         go(32'h84);
         begin
            wait (CORE_STALL_O === 1'b1);
            repeat (8) @(posedge CLOCK_I);
            SYS_RESET_I <= 1;
            @(posedge CLOCK_I);
            SYS_RESET_I <= 0;
         end
      join
      rd(OFS_CTRL, 32'h88);
      compare("long writes", 34'd4, 34'(n_long));
      conclude();
   end
endmodule

// ===== hw/pfsa_pkg.sv
// Shared constants for the program flash self-access block
// What this block does
// - Table fetch moves one byte per instruction
// - Fetch loads addressed byte, pointer optionally adjusted
// - Address bit zero picks high or low byte
// - Self erase always clears a 64-byte row
// - Erase row from pointer bits 21:6 only
// - Long write needs 55h, 0AAh, then go
// - Erase stalls core about 2 ms by timer
// - Long write stalls until programming timer expires
// - Programming unit is one 8-byte block
// - Eight holding registers, stores are short writes
// - Holding registers return to FFh after reset/program
// - FFh holding byte leaves flash byte unchanged
// - Go bit set-only, hardware clears at end
// - Completion flag set by hardware, core clears
// - Pointer 2:0 picks holding register, 21:3 block
// - Abort flag on reset abort or improper start
package pfsa_pkg;
   localparam int          CLK_PERIOD_PS   = 8000;
   localparam longint      LONG_WRITE_US   = 2000;
   // Longest time, so the division rounds down
   localparam int          LONG_WRITE_CYC  =
      int'((LONG_WRITE_US * 1000000) / CLK_PERIOD_PS);
   localparam int          TMR_W           = 24;

   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_KEY         = 8'h04;
   localparam logic [7:0]  OFS_PTR         = 8'h08;
   localparam logic [7:0]  OFS_LATCH       = 8'h0C;
   localparam logic [7:0]  OFS_TBLOP       = 8'h10;
   localparam logic [7:0]  OFS_STAT        = 8'h14;

   localparam int          B_PSEL          = 7;
   localparam int          B_CSEL          = 6;
   localparam int          B_ERASE         = 4;
   localparam int          B_ABORT         = 3;
   localparam int          B_ALLOW         = 2;
   localparam int          B_GO            = 1;
   localparam int          B_DONE_FLAG     = 0;
   localparam int          B_BUSY          = 1;
   localparam int          B_OP_STORE      = 0;
   localparam int          B_MODE_LO       = 1;

   localparam logic [7:0]  KEY_FIRST       = 8'h55;
   localparam logic [7:0]  KEY_SECOND      = 8'hAA;
   localparam logic [7:0]  HOLD_RESET      = 8'hFF;
   localparam int          PTR_W           = 22;
   localparam int          WADDR_W         = 21;
   localparam int          NHOLD           = 8;
   localparam int          ROW_LSB         = 6;
   localparam int          BLK_LSB         = 3;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {
      PM_KEEP    = 2'h0,
      PM_POSTINC = 2'h1,
      PM_POSTDEC = 2'h2,
      PM_PREINC  = 2'h3
   } pfsa_pmode_e;

   typedef enum logic [3:0] {
      WS_IDLE  = 4'h1,
      WS_FETCH = 4'h2,
      WS_LONG  = 4'h4,
      WS_RESP  = 4'h8
   } pfsa_wst_e;
endpackage

// ===== hw/pfsa_timer.sv
// Internal programming timer that ends each long write not aborted by device reset
`timescale 1ns/1ps
module pfsa_timer
   import pfsa_pkg::*;
(
   input  wire logic             clk_i,    // Core clock
   input  wire logic             nrst_i,   // Async reset, low
   input  wire logic             load_i,   // Start a timed cycle
   input  wire logic             abort_i,  // Stop without done
   input  wire logic [TMR_W-1:0] cycles_i, // Cycle count
   output logic                  done_o    // One-cycle end pulse
);
   logic [TMR_W-1:0] cnt_r;
   logic [TMR_W-1:0] cnt_nxt;
   logic             run_r;
   logic             run_nxt;
   logic             done_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      run_nxt  = run_r;
      done_nxt = 1'b0;
      if (abort_i) begin
         run_nxt = 1'b0;
      end else if (load_i) begin
         cnt_nxt = cycles_i;
         run_nxt = 1'b1;
      end else if (run_r) begin
         if (cnt_r <= TMR_W'(1)) begin
            run_nxt  = 1'b0;
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r  <= '0;
         run_r  <= 1'b0;
         done_o <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         run_r  <= run_nxt;
         done_o <= done_nxt;
      end
   end
endmodule

// ===== hw/pfsa_top.sv
// Program flash self-access sequencer with AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module pfsa_top
   import pfsa_pkg::*;
#(
   parameter int ERASE_CYCLES = LONG_WRITE_CYC, // Row erase time
   parameter int PROG_CYCLES  = LONG_WRITE_CYC  // Block program time
)(
   input  wire logic               CLOCK_I,         // 125 MHz core clock
   input  wire logic               NRST_I,          // Async reset, low
   input  wire logic               SYS_RESET_I,     // Device reset pulse
   input  wire logic [7:0]         S_AXI_AWADDR_I,  // Write address
   input  wire logic               S_AXI_AWVALID_I, // Write addr valid
   output logic                    S_AXI_AWREADY_O, // Write addr ready
   input  wire logic [31:0]        S_AXI_WDATA_I,   // Write data
   input  wire logic [3:0]         S_AXI_WSTRB_I,   // Byte enables
   input  wire logic               S_AXI_WVALID_I,  // Write data valid
   output logic                    S_AXI_WREADY_O,  // Write data ready
   output logic [1:0]              S_AXI_BRESP_O,   // Write response
   output logic                    S_AXI_BVALID_O,  // Response valid
   input  wire logic               S_AXI_BREADY_I,  // Response ready
   input  wire logic [7:0]         S_AXI_ARADDR_I,  // Read address
   input  wire logic               S_AXI_ARVALID_I, // Read addr valid
   output logic                    S_AXI_ARREADY_O, // Read addr ready
   output logic [31:0]             S_AXI_RDATA_O,   // Read data
   output logic [1:0]              S_AXI_RRESP_O,   // Read response
   output logic                    S_AXI_RVALID_O,  // Read data valid
   input  wire logic               S_AXI_RREADY_I,  // Read data ready
   output logic [WADDR_W-1:0]      FL_ADDR_O,       // Flash word address
   output logic                    FL_RD_O,         // Word read strobe
   input  wire logic [15:0]        FL_RDATA_I,      // Word, next cycle
   output logic                    FL_ERASE_O,      // Row erase active
   output logic                    FL_PROG_O,       // Block program active
   output logic [NHOLD*8-1:0]      FL_WDATA_O,      // Block data
   output logic [NHOLD-1:0]        FL_WMASK_O,      // Bytes to program
   output logic                    CORE_STALL_O     // Core halted
);
   logic [7:0]         hold_r [NHOLD];
   logic [7:0]         hold_nxt [NHOLD];
   logic [PTR_W-1:0]   ptr_r, ptr_nxt;
   logic [7:0]         latch_r, latch_nxt;
   logic               psel_r, psel_nxt, csel_r, csel_nxt;
   logic               erase_r, erase_nxt, allow_r, allow_nxt;
   logic               abort_r, abort_nxt, go_r, go_nxt;
   logic               dflag_r, dflag_nxt;
   logic [1:0]         key_r, key_nxt;
   logic               byte_hi_r, byte_hi_nxt;
   pfsa_wst_e          wst_r, wst_nxt;
   logic               aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt;
   logic [7:0]         awaddr_r, awaddr_nxt;
   logic [31:0]        wdata_r, wdata_nxt;
   logic [3:0]         wstrb_r, wstrb_nxt;
   logic [1:0]         bresp_r, bresp_nxt;
   logic               bvalid_r, bvalid_nxt;
   logic               arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [31:0]        rdata_r, rdata_nxt;
   logic [1:0]         rresp_r, rresp_nxt;
   logic [WADDR_W-1:0] fl_addr_r, fl_addr_nxt;
   logic               fl_rd_r, fl_rd_nxt;
   logic               fl_erase_r, fl_erase_nxt, fl_prog_r, fl_prog_nxt;
   logic [NHOLD*8-1:0] fl_wdata_r, fl_wdata_nxt;
   logic [NHOLD-1:0]   fl_wmask_r, fl_wmask_nxt;
   logic               tmr_load, tmr_abort, tmr_done;
   logic [TMR_W-1:0]   tmr_cycles;

   // Address the table instruction works on
   function automatic logic [PTR_W-1:0] op_addr(
      input logic [PTR_W-1:0] p, input logic [1:0] m);
      op_addr = p;
      if (m == PM_PREINC) begin
         op_addr = {p[PTR_W-1], p[WADDR_W-1:0] + WADDR_W'(1)};
      end
   endfunction

   // Pointer after the instruction; only the low 21 bits move
   function automatic logic [PTR_W-1:0] ptr_after(
      input logic [PTR_W-1:0] p, input logic [1:0] m);
      ptr_after = p;
      if (m == PM_POSTINC || m == PM_PREINC) begin
         ptr_after = {p[PTR_W-1], p[WADDR_W-1:0] + WADDR_W'(1)};
      end else if (m == PM_POSTDEC) begin
         ptr_after = {p[PTR_W-1], p[WADDR_W-1:0] - WADDR_W'(1)};
      end
   endfunction

   // Byte-enable merge, used by several registers
   function automatic logic [31:0] merge(
      input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   always_comb begin
      logic [31:0]      cv;
      logic [PTR_W-1:0] a;
      logic             ok;
      cv           = '0;
      a            = '0;
      ok           = 1'b0;
      hold_nxt     = hold_r;
      ptr_nxt      = ptr_r;
      latch_nxt    = latch_r;
      psel_nxt     = psel_r;
      csel_nxt     = csel_r;
      erase_nxt    = erase_r;
      allow_nxt    = allow_r;
      abort_nxt    = abort_r;
      go_nxt       = go_r;
      dflag_nxt    = dflag_r;
      key_nxt      = key_r;
      byte_hi_nxt  = byte_hi_r;
      wst_nxt      = wst_r;
      aw_rdy_nxt   = aw_rdy_r;
      w_rdy_nxt    = w_rdy_r;
      awaddr_nxt   = awaddr_r;
      wdata_nxt    = wdata_r;
      wstrb_nxt    = wstrb_r;
      bresp_nxt    = bresp_r;
      bvalid_nxt   = bvalid_r;
      fl_addr_nxt  = fl_addr_r;
      fl_rd_nxt    = 1'b0;
      fl_erase_nxt = fl_erase_r;
      fl_prog_nxt  = fl_prog_r;
      fl_wdata_nxt = fl_wdata_r;
      fl_wmask_nxt = fl_wmask_r;
      tmr_load     = 1'b0;
      tmr_abort    = 1'b0;
      tmr_cycles   = TMR_W'(PROG_CYCLES);

      if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
         aw_rdy_nxt  = 1'b0;
         awaddr_nxt  = S_AXI_AWADDR_I;
      end
      if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
         w_rdy_nxt  = 1'b0;
         wdata_nxt  = S_AXI_WDATA_I;
         wstrb_nxt  = S_AXI_WSTRB_I;
      end

      case (wst_r)
         WS_IDLE: begin
            if (!aw_rdy_r && !w_rdy_r) begin
               aw_rdy_nxt  = 1'b1;
               w_rdy_nxt   = 1'b1;
               bresp_nxt   = RESP_OKAY;
               bvalid_nxt  = 1'b1;
               wst_nxt     = WS_RESP;
               key_nxt     = 2'h0;
               a = op_addr(ptr_r, wdata_r[B_MODE_LO +: 2]);
               case (awaddr_r)
                  OFS_CTRL: begin
                     cv = merge({24'h0, psel_r, csel_r, 1'b0, erase_r,
                                 abort_r, allow_r, go_r, 1'b0},
                                wdata_r, wstrb_r);
                     psel_nxt  = cv[B_PSEL];
                     csel_nxt  = cv[B_CSEL];
                     erase_nxt = cv[B_ERASE];
                     allow_nxt = cv[B_ALLOW];
                     abort_nxt = cv[B_ABORT];
                     if (cv[B_GO] && !go_r) begin
                        ok = (key_r == 2'h2) && cv[B_ALLOW]
                             && cv[B_PSEL] && !cv[B_CSEL];
                        abort_nxt = 1'b1;
                        if (ok) begin
                           go_nxt     = 1'b1;
                           tmr_load   = 1'b1;
                           bvalid_nxt = 1'b0;
                           wst_nxt    = WS_LONG;
                           if (cv[B_ERASE]) begin
                              tmr_cycles   = TMR_W'(ERASE_CYCLES);
                              fl_erase_nxt = 1'b1;
                              fl_addr_nxt  = {ptr_r[PTR_W-1:ROW_LSB],
                                 (ROW_LSB-1)'(0)};
                           end else begin
                              fl_prog_nxt = 1'b1;
                              fl_addr_nxt = {ptr_r[PTR_W-1:BLK_LSB],
                                 (BLK_LSB-1)'(0)};
                              for (int i = 0; i < NHOLD; i++) begin
                                 fl_wdata_nxt[i*8 +: 8] = hold_r[i];
                                 fl_wmask_nxt[i] =
                                    (hold_r[i] != HOLD_RESET);
                              end
                           end
                        end
                     end
                  end
                  OFS_KEY: begin
                     if (wstrb_r[0]) begin
                        if (wdata_r[7:0] == KEY_FIRST) begin
                           key_nxt = 2'h1;
                        end else if (wdata_r[7:0] == KEY_SECOND
                                     && key_r == 2'h1) begin
                           key_nxt = 2'h2;
                        end
                     end
                  end
                  OFS_PTR: begin
                     cv      = merge({10'h0, ptr_r}, wdata_r, wstrb_r);
                     ptr_nxt = cv[PTR_W-1:0];
                  end
                  OFS_LATCH: begin
                     cv        = merge({24'h0, latch_r}, wdata_r,
                                       wstrb_r);
                     latch_nxt = cv[7:0];
                  end
                  OFS_TBLOP: begin
                     if (wstrb_r[0]) begin
                        ptr_nxt = ptr_after(ptr_r,
                           wdata_r[B_MODE_LO +: 2]);
                        if (wdata_r[B_OP_STORE]) begin
                           // Short write: array untouched
                           hold_nxt[a[BLK_LSB-1:0]] = latch_r;
                        end else begin
                           fl_addr_nxt = a[PTR_W-1:1];
                           byte_hi_nxt = a[0];
                           fl_rd_nxt   = 1'b1;
                           bvalid_nxt  = 1'b0;
                           wst_nxt     = WS_FETCH;
                        end
                     end
                  end
                  OFS_STAT: begin
                     if (wstrb_r[0] && wdata_r[B_DONE_FLAG]) begin
                        dflag_nxt = 1'b0;
                     end
                  end
                  default: begin
                     bresp_nxt = RESP_SLVERR;
                  end
               endcase
            end
         end
         WS_FETCH: begin
            latch_nxt  = byte_hi_r ? FL_RDATA_I[15:8]
                                   : FL_RDATA_I[7:0];
            bvalid_nxt = 1'b1;
            wst_nxt    = WS_RESP;
         end
         WS_LONG: begin
            // Response withheld, so the core sees the whole cycle
            if (tmr_done) begin
               go_nxt       = 1'b0;
               erase_nxt    = 1'b0;
               abort_nxt    = 1'b0;
               dflag_nxt    = 1'b1;
               fl_erase_nxt = 1'b0;
               fl_prog_nxt  = 1'b0;
               if (fl_prog_r) begin
                  for (int i = 0; i < NHOLD; i++) begin
                     hold_nxt[i] = HOLD_RESET;
                  end
               end
               bvalid_nxt = 1'b1;
               wst_nxt    = WS_RESP;
            end
         end
         WS_RESP: begin
            if (S_AXI_BREADY_I) begin
               bvalid_nxt = 1'b0;
               wst_nxt    = WS_IDLE;
            end
         end
         default: begin
            bvalid_nxt = 1'b0;
            wst_nxt    = WS_IDLE;
         end
      endcase

      // Device reset ends a timed cycle early; abort flag and
      // space selects survive so software can trace it
      if (SYS_RESET_I) begin
         for (int i = 0; i < NHOLD; i++) begin
            hold_nxt[i] = HOLD_RESET;
         end
         tmr_abort    = 1'b1;
         go_nxt       = 1'b0;
         erase_nxt    = 1'b0;
         allow_nxt    = 1'b0;
         key_nxt      = 2'h0;
         fl_erase_nxt = 1'b0;
         fl_prog_nxt  = 1'b0;
         if (wst_r == WS_LONG) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            wst_nxt    = WS_RESP;
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         for (int i = 0; i < NHOLD; i++) begin
            hold_r[i] <= HOLD_RESET;
         end
         ptr_r      <= '0;
         latch_r    <= '0;
         psel_r     <= 1'b0;
         csel_r     <= 1'b0;
         erase_r    <= 1'b0;
         allow_r    <= 1'b0;
         abort_r    <= 1'b0;
         go_r       <= 1'b0;
         dflag_r    <= 1'b0;
         key_r      <= 2'h0;
         byte_hi_r  <= 1'b0;
         wst_r      <= WS_IDLE;
         aw_rdy_r   <= 1'b1;
         w_rdy_r    <= 1'b1;
         awaddr_r   <= '0;
         wdata_r    <= '0;
         wstrb_r    <= '0;
         bresp_r    <= RESP_OKAY;
         bvalid_r   <= 1'b0;
         fl_addr_r  <= '0;
         fl_rd_r    <= 1'b0;
         fl_erase_r <= 1'b0;
         fl_prog_r  <= 1'b0;
         fl_wdata_r <= '0;
         fl_wmask_r <= '0;
      end else begin
         hold_r     <= hold_nxt;
         ptr_r      <= ptr_nxt;
         latch_r    <= latch_nxt;
         psel_r     <= psel_nxt;
         csel_r     <= csel_nxt;
         erase_r    <= erase_nxt;
         allow_r    <= allow_nxt;
         abort_r    <= abort_nxt;
         go_r       <= go_nxt;
         dflag_r    <= dflag_nxt;
         key_r      <= key_nxt;
         byte_hi_r  <= byte_hi_nxt;
         wst_r      <= wst_nxt;
         aw_rdy_r   <= aw_rdy_nxt;
         w_rdy_r    <= w_rdy_nxt;
         awaddr_r   <= awaddr_nxt;
         wdata_r    <= wdata_nxt;
         wstrb_r    <= wstrb_nxt;
         bresp_r    <= bresp_nxt;
         bvalid_r   <= bvalid_nxt;
         fl_addr_r  <= fl_addr_nxt;
         fl_rd_r    <= fl_rd_nxt;
         fl_erase_r <= fl_erase_nxt;
         fl_prog_r  <= fl_prog_nxt;
         fl_wdata_r <= fl_wdata_nxt;
         fl_wmask_r <= fl_wmask_nxt;
      end
   end

   // Read channel: one beat, answer one cycle after acceptance
   always_comb begin
      arready_nxt = arready_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (arready_r && S_AXI_ARVALID_I) begin
         arready_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rresp_nxt   = RESP_OKAY;
         rdata_nxt   = '0;
         case (S_AXI_ARADDR_I)
            OFS_CTRL:  rdata_nxt = {24'h0, psel_r, csel_r, 1'b0, erase_r,
                                    abort_r, allow_r, go_r, 1'b0};
            OFS_KEY:   rdata_nxt = '0;
            OFS_PTR:   rdata_nxt = {10'h0, ptr_r};
            OFS_LATCH: rdata_nxt = {24'h0, latch_r};
            OFS_TBLOP: rdata_nxt = '0;
            OFS_STAT:  rdata_nxt = {30'h0, go_r, dflag_r};
            default:   rresp_nxt = RESP_SLVERR;
         endcase
      end else if (rvalid_r && S_AXI_RREADY_I) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else begin
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   pfsa_timer u_timer (
      .clk_i    (CLOCK_I),
      .nrst_i   (NRST_I),
      .load_i   (tmr_load),
      .abort_i  (tmr_abort),
      .cycles_i (tmr_cycles),
      .done_o   (tmr_done)
   );

   assign S_AXI_AWREADY_O = aw_rdy_r;
   assign S_AXI_WREADY_O  = w_rdy_r;
   assign S_AXI_BRESP_O   = bresp_r;
   assign S_AXI_BVALID_O  = bvalid_r;
   assign S_AXI_ARREADY_O = arready_r;
   assign S_AXI_RDATA_O   = rdata_r;
   assign S_AXI_RRESP_O   = rresp_r;
   assign S_AXI_RVALID_O  = rvalid_r;
   assign FL_ADDR_O       = fl_addr_r;
   assign FL_RD_O         = fl_rd_r;
   assign FL_ERASE_O      = fl_erase_r;
   assign FL_PROG_O       = fl_prog_r;
   assign FL_WDATA_O      = fl_wdata_r;
   assign FL_WMASK_O      = fl_wmask_r;
   assign CORE_STALL_O    = go_r;
endmodule
